/* include/pcc_params.svh */
// offsets, field positions, reset values and fixed codes of the command/class/revision block
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ****************************************************************
// configuration offsets (byte addresses of dwords and of single bytes)
// ****************************************************************
`define PCC_OFF_COMMAND        8'h04
`define PCC_OFF_REVISION       8'h08
`define PCC_OFF_CLASS_PROG     8'h09
`define PCC_OFF_CLASS_SUB      8'h0a
`define PCC_OFF_CLASS_BASE     8'h0b

// ****************************************************************
// command field positions
// ****************************************************************
`define PCC_CMD_IO_SPACE       0
`define PCC_CMD_MEM_SPACE      1
`define PCC_CMD_BUS_MASTER     2
`define PCC_CMD_WR_INVAL       4
`define PCC_CMD_PAL_SNOOP      5
`define PCC_CMD_SYS_ERR        8
`define PCC_CMD_WRITABLE       16'h0137
`define PCC_CMD_RESET          16'h0000

// ****************************************************************
// status field position within the dword at the command offset
// ****************************************************************
`define PCC_STAT_SYS_ERR       30
`define PCC_STAT_RESET         1'b0

// ****************************************************************
// fixed identification values
// ****************************************************************
`define PCC_CLASS_CODE         24'h030000

// ****************************************************************
// legacy vga decode bounds
// ****************************************************************
`define PCC_IO_MONO_LO         10'h3b0
`define PCC_IO_MONO_HI         10'h3bb
`define PCC_IO_COLOR_LO        10'h3c0
`define PCC_IO_COLOR_HI        10'h3df
`define PCC_IO_PAL_LO          10'h3c6
`define PCC_IO_PAL_HI          10'h3c9
`define PCC_VGA_A0000          32'h000a0000
`define PCC_VGA_B0000          32'h000b0000
`define PCC_VGA_B8000          32'h000b8000
`define PCC_VGA_C0000          32'h000c0000

`endif

/* include/pcc_pkg.sv */
// types shared by the command/class/revision block
package pcc_pkg;

  // ****************************************************************
  // memory-map select field of the graphics misc register
  // ****************************************************************
  typedef enum logic [1:0] {
    PCC_MAP_128K   = 2'b00,
    PCC_MAP_A64K   = 2'b01,
    PCC_MAP_B32K   = 2'b10,
    PCC_MAP_B8_32K = 2'b11
  } pcc_vga_map_t;

  // ****************************************************************
  // bus commands used as master
  // ****************************************************************
  typedef enum logic [3:0] {
    PCC_BUS_MEM_WRITE = 4'h7,
    PCC_BUS_MEM_WINV  = 4'hf
  } pcc_bus_cmd_t;

endpackage : pcc_pkg

/* core/pcc_config.sv */
// command, class code and revision configuration registers with their gating logic
`timescale 1ns/1ps
`include "pcc_params.svh"

// Notes on behaviour
// - system-error pin driven only while command bit 8 is set
// - command bit 5 enables palette snooping; otherwise palette handled normally
// - write-and-invalidate as master only with command bit 4; else plain write
// - no initiator transactions while command bit 2 is clear
// - command bit 1 enables claiming both 16MB windows and vga memory
// - vga memory range follows map select field and its enable
// - command bit 0 enables vga io ports 3b0-3bb, 3c0-3df and aliases
// - class code bits 31:8 read 030000, read only
// - class code bytes at 0b, 0a, 09 readable individually
// - byte 08 returns read-only vendor-chosen revision value
// - status bit 30 set whenever the system-error pin is asserted

module pcc_config #(
  parameter logic [7:0] REVISION = 8'h5a   // arbitrary value
) (
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // configuration access
  input  wire logic                  cfg_rd,
  input  wire logic                  cfg_wr,
  input  wire logic [7:0]            cfg_addr,
  input  wire logic [3:0]            cfg_be,
  input  wire logic [31:0]           cfg_wdata,
  output logic      [31:0]           cfg_rdata,
  output logic                       cfg_rvalid,
  // system error
  input  wire logic                  sys_err_event,
  output logic                       serr_out,
  output logic                       serr_oe,
  // bus master requests
  input  wire logic                  mst_req,
  input  wire pcc_pkg::pcc_bus_cmd_t mst_cmd,
  output logic                       mst_go,
  output pcc_pkg::pcc_bus_cmd_t      mst_cmd_out,
  // memory decode
  input  wire logic                  mem_cyc,
  input  wire logic [31:0]           mem_addr,
  input  wire logic [7:0]            bar0_base,
  input  wire logic [7:0]            bar1_base,
  input  wire pcc_pkg::pcc_vga_map_t vga_map_sel,
  input  wire logic                  vga_mem_en,
  output logic                       mem_claim,
  // io decode
  input  wire logic                  io_cyc,
  input  wire logic                  io_write,
  input  wire logic [15:0]           io_addr,
  output logic                       io_claim,
  output logic                       pal_snoop,
  // command state
  output logic [15:0]                cmd_state
);
  import pcc_pkg::*;

  localparam logic [7:0]  OFF_CMD      = `PCC_OFF_COMMAND;
  localparam logic [7:0]  OFF_REV      = `PCC_OFF_REVISION;
  localparam logic [15:0] CMD_WRITABLE = `PCC_CMD_WRITABLE;

  logic [15:0] pci_command_reg;
  logic        sys_err_flagged_reg;
  logic        hit_cmd;
  logic        hit_rev;
  logic        vga_mem_hit;
  logic        io_hit;
  logic        pal_hit;
  logic [9:0]  io_low;
  logic        sys_err_drive_en;
  logic        write_invalidate_en;

  assign hit_cmd             = cfg_addr[7:2] == OFF_CMD[7:2];
  assign hit_rev             = cfg_addr[7:2] == OFF_REV[7:2];
  assign sys_err_drive_en    = pci_command_reg[`PCC_CMD_SYS_ERR];
  assign write_invalidate_en = pci_command_reg[`PCC_CMD_WR_INVAL];
  assign cmd_state           = pci_command_reg;

  // ****************************************************************
  // command register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pci_command_reg <= `PCC_CMD_RESET;
    end else if (ce && cfg_wr && hit_cmd) begin
      if (cfg_be[0]) begin
        pci_command_reg[7:0] <= cfg_wdata[7:0] & CMD_WRITABLE[7:0];
      end
      if (cfg_be[1]) begin
        pci_command_reg[15:8] <= cfg_wdata[15:8] & CMD_WRITABLE[15:8];
      end
    end
  end

  // ****************************************************************
  // system error pin and its status flag
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_oe <= 1'b0;
    end else if (ce) begin
      serr_oe <= sys_err_event && sys_err_drive_en;
    end
  end

  assign serr_out = 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      sys_err_flagged_reg <= `PCC_STAT_RESET;
    end else if (ce) begin
      if (serr_oe) begin
        sys_err_flagged_reg <= 1'b1;
      end else if (cfg_wr && hit_cmd && cfg_be[3] && cfg_wdata[`PCC_STAT_SYS_ERR]) begin
        sys_err_flagged_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // configuration reads
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        if (hit_cmd) begin
          cfg_rdata <= {1'b0, sys_err_flagged_reg, 14'h0000, pci_command_reg};
        end else if (hit_rev) begin
          cfg_rdata <= {`PCC_CLASS_CODE, REVISION};
        end else begin
          cfg_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************************************
  // bus master gating
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      mst_go      <= 1'b0;
      mst_cmd_out <= PCC_BUS_MEM_WRITE;
    end else if (ce) begin
      mst_go <= mst_req && pci_command_reg[`PCC_CMD_BUS_MASTER];
      if (mst_cmd == PCC_BUS_MEM_WINV && !write_invalidate_en) begin
        mst_cmd_out <= PCC_BUS_MEM_WRITE;
      end else begin
        mst_cmd_out <= mst_cmd;
      end
    end
  end

  // ****************************************************************
  // memory decode
  // ****************************************************************
  always_comb begin
    vga_mem_hit = 1'b0;
    unique case (vga_map_sel)
      PCC_MAP_128K: begin
        vga_mem_hit = mem_addr >= `PCC_VGA_A0000 && mem_addr < `PCC_VGA_C0000;
      end
      PCC_MAP_A64K: begin
        vga_mem_hit = mem_addr >= `PCC_VGA_A0000 && mem_addr < `PCC_VGA_B0000;
      end
      PCC_MAP_B32K: begin
        vga_mem_hit = mem_addr >= `PCC_VGA_B0000 && mem_addr < `PCC_VGA_B8000;
      end
      PCC_MAP_B8_32K: begin
        vga_mem_hit = mem_addr >= `PCC_VGA_B8000 && mem_addr < `PCC_VGA_C0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_claim <= 1'b0;
    end else if (ce) begin
      mem_claim <= mem_cyc && pci_command_reg[`PCC_CMD_MEM_SPACE] &&
                   (mem_addr[31:24] == bar0_base || mem_addr[31:24] == bar1_base ||
                    (vga_mem_en && vga_mem_hit));
    end
  end

  // ****************************************************************
  // io decode, ten-bit aliasing
  // ****************************************************************
  assign io_low  = io_addr[9:0];
  assign io_hit  = (io_low >= `PCC_IO_MONO_LO && io_low <= `PCC_IO_MONO_HI) ||
                   (io_low >= `PCC_IO_COLOR_LO && io_low <= `PCC_IO_COLOR_HI);
  assign pal_hit = io_low >= `PCC_IO_PAL_LO && io_low <= `PCC_IO_PAL_HI;

  always_ff @(posedge clk) begin
    if (rst) begin
      io_claim  <= 1'b0;
      pal_snoop <= 1'b0;
    end else if (ce) begin
      if (io_cyc && io_hit && pci_command_reg[`PCC_CMD_IO_SPACE]) begin
        if (pal_hit && io_write && pci_command_reg[`PCC_CMD_PAL_SNOOP]) begin
          io_claim  <= 1'b0;
          pal_snoop <= 1'b1;
        end else begin
          io_claim  <= 1'b1;
          pal_snoop <= 1'b0;
        end
      end else begin
        io_claim  <= 1'b0;
        pal_snoop <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  serr_gate_a: assert property (@(posedge clk) disable iff (rst)
    $rose(serr_oe) |-> $past(sys_err_drive_en) && $past(sys_err_event))
    else $error("system error driven while disabled");

  serr_flag_a: assert property (@(posedge clk) disable iff (rst)
    ce && serr_oe |=> sys_err_flagged_reg)
    else $error("status flag not set after system error");

  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && !serr_oe && cfg_wr && hit_cmd && cfg_be[3] && cfg_wdata[`PCC_STAT_SYS_ERR]
    |=> !sys_err_flagged_reg)
    else $error("status flag not cleared by write");

  mst_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && !pci_command_reg[`PCC_CMD_BUS_MASTER] |=> !mst_go)
    else $error("master started while disabled");

  winv_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && !write_invalidate_en |=> mst_cmd_out != PCC_BUS_MEM_WINV)
    else $error("write and invalidate used while disabled");

  mem_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && !pci_command_reg[`PCC_CMD_MEM_SPACE] |=> !mem_claim)
    else $error("memory claimed while disabled");

  io_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && !pci_command_reg[`PCC_CMD_IO_SPACE] |=> !io_claim && !pal_snoop)
    else $error("io claimed while disabled");

  snoop_gate_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pal_snoop) |-> $past(pci_command_reg[`PCC_CMD_PAL_SNOOP]) && !io_claim)
    else $error("palette snoop without enable");

  class_read_a: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_rd && hit_rev |=> cfg_rvalid && cfg_rdata == {`PCC_CLASS_CODE, REVISION})
    else $error("class or revision read wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    (pci_command_reg & ~`PCC_CMD_WRITABLE) == 16'h0000)
    else $error("reserved command bit set");

endmodule : pcc_config

/* sim/pcc_host_model.sv */
// host bridge model issuing configuration reads and writes
`timescale 1ns/1ps

module pcc_host_model (
  // clock
  input  wire logic        clk,
  // configuration access
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid
);
  initial begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
  end

  // one write cycle; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1 cfg_wr = 1'b1;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    @(posedge clk);
    #1 cfg_wr = 1'b0;
    cfg_wdata = ~d;
    cfg_be    = 4'h0;
  endtask : wr

  // one read cycle; answer taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    #1 cfg_rd = 1'b1;
    cfg_addr  = a;
    @(posedge clk);
    #1 cfg_rd = 1'b0;
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask : rd
endmodule : pcc_host_model

/* sim/tb_top.sv */
// self-checking testbench of the command/class/revision block
`timescale 1ns/1ps

module tb_top;
  import pcc_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         ce = 1'b1;
  logic         sys_err_event = 1'b0;
  logic         mst_req = 1'b0;
  pcc_bus_cmd_t mst_cmd = PCC_BUS_MEM_WRITE;
  logic         mem_cyc = 1'b0;
  logic [31:0]  mem_addr = 32'h0;
  pcc_vga_map_t vga_map_sel = PCC_MAP_128K;
  logic         vga_mem_en = 1'b0;
  logic         io_cyc = 1'b0;
  logic         io_write = 1'b0;
  logic [15:0]  io_addr = 16'h0;
  logic         cfg_rd, cfg_wr, cfg_rvalid, serr_out, serr_oe, mst_go, mem_claim;
  logic         io_claim, pal_snoop;
  logic [7:0]   cfg_addr;
  logic [3:0]   cfg_be;
  logic [31:0]  cfg_wdata, cfg_rdata;
  logic [15:0]  cmd_state;
  pcc_bus_cmd_t mst_cmd_out;
  int           bad_count = 0;
  int           num_checks = 0;

  always #2 clk = ~clk;

  pcc_host_model host (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

  pcc_config #(.REVISION(8'h5a)) dut (.clk(clk), .rst(rst), .ce(ce), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .sys_err_event(sys_err_event), .serr_out(serr_out),
    .serr_oe(serr_oe), .mst_req(mst_req), .mst_cmd(mst_cmd), .mst_go(mst_go),
    .mst_cmd_out(mst_cmd_out), .mem_cyc(mem_cyc), .mem_addr(mem_addr),
    .bar0_base(8'h12), .bar1_base(8'h34), .vga_map_sel(vga_map_sel),
    .vga_mem_en(vga_mem_en), .mem_claim(mem_claim), .io_cyc(io_cyc), .io_write(io_write),
    .io_addr(io_addr), .io_claim(io_claim), .pal_snoop(pal_snoop), .cmd_state(cmd_state));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic set_cmd(input logic [15:0] c);
    host.wr(8'h04, 4'h3, {16'h0, c});
    tick;
  endtask : set_cmd

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    host.rd(a, d, v);
    check("rvalid", {31'h0, v}, 32'h1);
    check(what, d, exp);
  endtask : rd_chk

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    check("cmd reset", {16'h0, cmd_state}, 32'h0);
    rd_chk("dword 04", 8'h04, 32'h0);
    rd_chk("class rev", 8'h08, 32'h0300005a);
    tick;
    check("rvalid drop", {31'h0, cfg_rvalid}, 32'h0);
    host.wr(8'h08, 4'hf, 32'hffffffff);
    tick;
    rd_chk("class base byte", 8'h0b, 32'h0300005a);
    set_cmd(16'hffff);
    check("cmd writable", {16'h0, cmd_state}, 32'h0137);
    rd_chk("unmapped", 8'h3c, 32'h0);
  endtask : t_regs

  task automatic t_serr;
    set_cmd(16'h0000);
    sys_err_event = 1'b1;
    tick;
    check("serr off", {31'h0, serr_oe}, 32'h0);
    set_cmd(16'h0100);
    check("serr on", {31'h0, serr_oe}, 32'h1);
    check("serr level", {31'h0, serr_out}, 32'h0);
    sys_err_event = 1'b0;
    tick;
    check("serr one", {31'h0, serr_oe}, 32'h0);
    rd_chk("flag set", 8'h04, 32'h40000100);
    host.wr(8'h04, 4'h8, 32'h40000000);
    tick;
    rd_chk("flag clr", 8'h04, 32'h00000100);
    sys_err_event = 1'b1;
    host.wr(8'h04, 4'h8, 32'h40000000);
    sys_err_event = 1'b0;
    tick;
    rd_chk("flag set wins", 8'h04, 32'h40000100);
  endtask : t_serr

  task automatic t_master;
    set_cmd(16'h0000);
    mst_req = 1'b1;
    mst_cmd = PCC_BUS_MEM_WINV;
    tick;
    check("go off", {31'h0, mst_go}, 32'h0);
    check("winv off", {28'h0, mst_cmd_out}, 32'h7);
    set_cmd(16'h0014);
    check("go on", {31'h0, mst_go}, 32'h1);
    check("winv on", {28'h0, mst_cmd_out}, 32'hf);
    mst_req = 1'b0;
    tick;
    check("go idle", {31'h0, mst_go}, 32'h0);
  endtask : t_master

  task automatic t_mem;
    logic [3:0] exp;
    exp = 4'b0101;
    set_cmd(16'h0000);
    mem_cyc = 1'b1;
    mem_addr = 32'h12000100;
    tick;
    check("mem off", {31'h0, mem_claim}, 32'h0);
    set_cmd(16'h0002);
    check("bar0", {31'h0, mem_claim}, 32'h1);
    mem_addr = 32'h34fffffc;
    tick;
    check("bar1", {31'h0, mem_claim}, 32'h1);
    mem_addr = 32'h000b0000;
    vga_mem_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      vga_map_sel = pcc_vga_map_t'(i[1:0]);
      tick;
      check("vga map", {31'h0, mem_claim}, {31'h0, exp[i]});
    end
    vga_mem_en = 1'b0;
    tick;
    check("vga off", {31'h0, mem_claim}, 32'h0);
    mem_cyc = 1'b0;
  endtask : t_mem

  task automatic t_io;
    set_cmd(16'h0000);
    io_cyc = 1'b1;
    io_addr = 16'h03b5;
    tick;
    check("io off", {31'h0, io_claim}, 32'h0);
    set_cmd(16'h0001);
    check("io mono", {31'h0, io_claim}, 32'h1);
    io_addr = 16'h03e0;
    tick;
    check("io above", {31'h0, io_claim}, 32'h0);
    io_addr = 16'h07c4;
    tick;
    check("io alias", {31'h0, io_claim}, 32'h1);
    io_addr = 16'h03c8;
    io_write = 1'b1;
    tick;
    check("pal plain", {30'h0, io_claim, pal_snoop}, 32'h2);
    set_cmd(16'h0021);
    check("pal snoop", {30'h0, io_claim, pal_snoop}, 32'h1);
    io_write = 1'b0;
    tick;
    check("pal read", {30'h0, io_claim, pal_snoop}, 32'h2);
    io_cyc = 1'b0;
  endtask : t_io

  task automatic t_ctrl;
    set_cmd(16'h0004);
    ce = 1'b0;
    host.wr(8'h04, 4'h3, 32'h0);
    mst_req = 1'b1;
    tick;
    check("frozen cmd", {16'h0, cmd_state}, 32'h0004);
    check("frozen go", {31'h0, mst_go}, 32'h0);
    ce = 1'b1;
    tick;
    check("go after ce", {31'h0, mst_go}, 32'h1);
    mst_req = 1'b0;
    rst = 1'b1;
    tick;
    tick;
    rst = 1'b0;
    check("cmd after rst", {16'h0, cmd_state}, 32'h0);
    check("go after rst", {31'h0, mst_go}, 32'h0);
    check("cmd out rst", {28'h0, mst_cmd_out}, 32'h7);
    rd_chk("dword 04 rst", 8'h04, 32'h0);
  endtask : t_ctrl

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_regs;
    t_serr;
    t_master;
    t_mem;
    t_io;
    t_ctrl;
    complete_run;
  end

  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule : tb_top
